// *** coe_consts.svh ***
/*
  Constants for the OR / subtract-from-literal execution slice.
  Assumes inclusion by the slice and its package users; no processes here.
*/
`ifndef COE_CONSTS_SVH
`define COE_CONSTS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define COE_OFF_ACC      8'h00
`define COE_OFF_BANK     8'h04
`define COE_OFF_STATUS   8'h08
`define COE_OFF_INSTR    8'h0C
`define COE_OFF_RESULT   8'h10

// ****************************************
// Instruction encodings and fields
// ****************************************
`define COE_OP_OR_LITERAL_INTO_ACCUMULATOR_HI  8'h09
`define COE_OP_SUBTRACT_ACCUMULATOR_FROM_LITERAL_HI  8'h08
`define COE_OP_OR_ACCUMULATOR_INTO_FILE_HI  6'h04
`define COE_DEST_BIT     9
`define COE_ACC_BIT      8
`define COE_FLAG_C       0
`define COE_FLAG_DC      1
`define COE_FLAG_Z       2
`define COE_FLAG_OV      3
`define COE_FLAG_N       4
`define COE_ACC_RST      8'h00
`define COE_BANK_RST     4'h0
`define COE_STATUS_RST   5'h00
`define COE_ACCESS_BANK  4'h0
`define COE_ACCESS_SPLIT 8'h80
`define COE_ACCESS_HIGH  4'hF
`define COE_RESP_OKAY    2'h0
`define COE_RESP_SLVERR  2'h2

`endif

// *** coe_pkg.sv ***
/*
  Types for the OR / subtract-from-literal execution slice.
  Assumes coe_consts.svh is compiled alongside.
*/
`default_nettype none
package coe_pkg;
  typedef enum logic [1:0] {COE_OP_NONE, COE_OP_ORLIT, COE_OP_ORFILE, COE_OP_SUBLIT} coe_op_e;
  typedef enum logic [1:0] {COE_ST_IDLE, COE_ST_READ, COE_ST_WRITE} coe_state_e;
endpackage
`default_nettype wire

// *** coe_alu.sv ***
/*
  Combinational ALU for the OR and subtract-from-literal operations.
  Assumes the caller registers its outputs and holds the flag register.
*/
`timescale 1ns/1ps
`default_nettype none
`include "coe_consts.svh"

module coe_alu
(
  // Operation select
  input  wire coe_pkg::coe_op_e op,
  // Operands
  input  wire logic [7:0]       acc,
  input  wire logic [7:0]       operand,
  input  wire logic [4:0]       flags_in,
  // Result
  output logic      [7:0]       result,
  output logic      [4:0]       flags_out
);
  logic [8:0] diff;
  logic [4:0] ldiff;

  always_comb
  begin
    result    = 8'h00;
    flags_out = flags_in;
    diff      = {1'b0, operand} - {1'b0, acc};
    ldiff     = {1'b0, operand[3:0]} - {1'b0, acc[3:0]};
    case (op)
      coe_pkg::COE_OP_ORLIT, coe_pkg::COE_OP_ORFILE:
      begin
        result                = acc | operand; // RULE1
        flags_out[`COE_FLAG_N] = result[7]; // RULE7
        flags_out[`COE_FLAG_Z] = (result == 8'h00); // RULE7
      end
      coe_pkg::COE_OP_SUBLIT:
      begin
        // Borrow-style carry: set means no borrow
        result                 = diff[7:0]; // RULE6
        flags_out[`COE_FLAG_C]  = ~diff[8]; // RULE6
        flags_out[`COE_FLAG_DC] = ~ldiff[4];
        flags_out[`COE_FLAG_Z]  = (diff[7:0] == 8'h00); // RULE6
        flags_out[`COE_FLAG_N]  = diff[7]; // RULE6
        flags_out[`COE_FLAG_OV] = (operand[7] != acc[7]) && (diff[7] != operand[7]);
      end
      default:
      begin
        result    = 8'h00;
        flags_out = flags_in;
      end
    endcase
  end
endmodule
`default_nettype wire

// *** coe_exec.sv ***
/*
  Execution slice for OR-literal, OR-file and subtract-from-literal.
  Software feeds instructions over AXI4-Lite; the banked data memory is external,
  combinationally read and written one word per cycle.
*/
//
// Summary of operation
// RULE1: OR file operand with accumulator
// RULE2: destination clear writes accumulator only
// RULE3: destination set writes back file register
// RULE4: access clear selects fixed access bank
// RULE5: access set uses bank select register
// RULE6: literal above accumulator: positive, carry set
// RULE7: OR single cycle; flags N, Z
`timescale 1ns/1ps
`default_nettype none
`include "coe_consts.svh"

module coe_exec
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // AXI4-Lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic      [1:0]  s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  // AXI4-Lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  // Banked data memory
  output logic      [11:0] dmem_addr,
  input  wire logic [7:0]  dmem_rdata,
  output logic             dmem_we,
  output logic      [7:0]  dmem_wdata
);

  // ****************************************
  // Architectural state
  // ****************************************
  logic [7:0]  acc;
  logic [7:0]  next_acc;
  logic [3:0]  bank_select_reg;
  logic [3:0]  next_bank_select_reg;
  logic [4:0]  status;
  logic [4:0]  next_status;
  logic [7:0]  result_q;
  logic [7:0]  next_result_q;

  // ****************************************
  // Bus slave state
  // ****************************************
  logic        aw_held;
  logic        next_aw_held;
  logic [7:0]  aw_addr;
  logic [7:0]  next_aw_addr;
  logic        w_held;
  logic        next_w_held;
  logic [31:0] w_data;
  logic [31:0] next_w_data;
  logic [3:0]  w_strb;
  logic [3:0]  next_w_strb;
  logic        bvalid;
  logic        next_bvalid;
  logic [1:0]  bresp;
  logic [1:0]  next_bresp;
  logic        rvalid;
  logic        next_rvalid;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [1:0]  rresp;
  logic [1:0]  next_rresp;

  // ****************************************
  // Instruction decode
  // ****************************************
  logic [15:0]            instr;
  logic                   do_write;
  logic                   exec;
  coe_pkg::coe_op_e       op;
  logic [7:0]             operand;
  logic [7:0]             alu_result;
  logic [4:0]             alu_flags;
  logic                   dest_file;

  assign do_write = aw_held && w_held && !bvalid;
  assign instr    = w_data[15:0];
  assign exec     = do_write && (aw_addr == `COE_OFF_INSTR) && (&w_strb[1:0]);

  always_comb
  begin
    op = coe_pkg::COE_OP_NONE;
    if (instr[15:8] == `COE_OP_OR_LITERAL_INTO_ACCUMULATOR_HI)
      op = coe_pkg::COE_OP_ORLIT;
    else if (instr[15:8] == `COE_OP_SUBTRACT_ACCUMULATOR_FROM_LITERAL_HI)
      op = coe_pkg::COE_OP_SUBLIT;
    else if (instr[15:10] == `COE_OP_OR_ACCUMULATOR_INTO_FILE_HI)
      op = coe_pkg::COE_OP_ORFILE;
  end

  // Access bank: low half maps to bank 0, high half to the top bank
  always_comb
  begin
    if (instr[`COE_ACC_BIT])
      dmem_addr = {bank_select_reg, instr[7:0]}; // RULE5
    else if (instr[7:0] < `COE_ACCESS_SPLIT)
      dmem_addr = {`COE_ACCESS_BANK, instr[7:0]}; // RULE4
    else
      dmem_addr = {`COE_ACCESS_HIGH, instr[7:0]}; // RULE4
  end

  assign operand   = (op == coe_pkg::COE_OP_ORFILE) ? dmem_rdata : instr[7:0];
  assign dest_file = instr[`COE_DEST_BIT];

  coe_alu u_alu
  (
    .op        (op),
    .acc       (acc),
    .operand   (operand),
    .flags_in  (status),
    .result    (alu_result),
    .flags_out (alu_flags)
  );

  // Memory write-back happens in the same cycle as execution: single cycle
  assign dmem_we    = exec && (op == coe_pkg::COE_OP_ORFILE) && dest_file; // RULE3 RULE7
  assign dmem_wdata = alu_result;

  // ****************************************
  // Architectural next state
  // ****************************************
  always_comb
  begin
    next_acc             = acc;
    next_bank_select_reg = bank_select_reg;
    next_status          = status;
    next_result_q        = result_q;
    if (exec && op != coe_pkg::COE_OP_NONE)
    begin
      next_status   = alu_flags; // RULE7
      next_result_q = alu_result;
      if (op != coe_pkg::COE_OP_ORFILE || !dest_file)
        next_acc = alu_result; // RULE2 RULE6
    end
    else if (do_write)
    begin
      if (aw_addr == `COE_OFF_ACC && w_strb[0])
        next_acc = w_data[7:0];
      if (aw_addr == `COE_OFF_BANK && w_strb[0])
        next_bank_select_reg = w_data[3:0];
      if (aw_addr == `COE_OFF_STATUS && w_strb[0])
        next_status = w_data[4:0];
    end
  end

  // ****************************************
  // Bus next state
  // ****************************************
  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign s_axi_arready = !rvalid;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rdata   = rdata;
  assign s_axi_rresp   = rresp;

  always_comb
  begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    if (s_axi_awvalid && !aw_held)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (do_write)
    begin
      next_bvalid  = 1'b1;
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      case (aw_addr)
        `COE_OFF_ACC, `COE_OFF_BANK, `COE_OFF_STATUS, `COE_OFF_INSTR:
          next_bresp = `COE_RESP_OKAY;
        default:
          next_bresp = `COE_RESP_SLVERR;
      endcase
    end
    if (bvalid && s_axi_bready)
      next_bvalid = 1'b0;
    if (rvalid && s_axi_rready)
      next_rvalid = 1'b0;
    if (s_axi_arvalid && !rvalid)
    begin
      next_rvalid = 1'b1;
      next_rresp  = `COE_RESP_OKAY;
      case (s_axi_araddr)
        `COE_OFF_ACC:    next_rdata = {24'h000000, acc};
        `COE_OFF_BANK:   next_rdata = {28'h0000000, bank_select_reg};
        `COE_OFF_STATUS: next_rdata = {27'h0000000, status};
        `COE_OFF_INSTR:  next_rdata = 32'h00000000;
        `COE_OFF_RESULT: next_rdata = {24'h000000, result_q};
        default:
        begin
          next_rdata = 32'h00000000;
          next_rresp = `COE_RESP_SLVERR;
        end
      endcase
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      acc             <= `COE_ACC_RST;
      bank_select_reg <= `COE_BANK_RST;
      status          <= `COE_STATUS_RST;
      result_q        <= 8'h00;
      aw_held         <= 1'b0;
      aw_addr         <= 8'h00;
      w_held          <= 1'b0;
      w_data          <= 32'h00000000;
      w_strb          <= 4'h0;
      bvalid          <= 1'b0;
      bresp           <= 2'h0;
      rvalid          <= 1'b0;
      rdata           <= 32'h00000000;
      rresp           <= 2'h0;
    end
    else
    begin
      acc             <= next_acc;
      bank_select_reg <= next_bank_select_reg;
      status          <= next_status;
      result_q        <= next_result_q;
      aw_held         <= next_aw_held;
      aw_addr         <= next_aw_addr;
      w_held          <= next_w_held;
      w_data          <= next_w_data;
      w_strb          <= next_w_strb;
      bvalid          <= next_bvalid;
      bresp           <= next_bresp;
      rvalid          <= next_rvalid;
      rdata           <= next_rdata;
      rresp           <= next_rresp;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  logic is_or;
  assign is_or = exec && (op == coe_pkg::COE_OP_ORLIT || op == coe_pkg::COE_OP_ORFILE);

  property p_or_value;
    @(posedge core_clk) disable iff (sys_rst)
      exec && op == coe_pkg::COE_OP_ORFILE && !dest_file |=> acc == $past(acc | dmem_rdata);
  endproperty
  a_or_value: assert property (p_or_value) else $error("OR result wrong"); // RULE1
  property p_dest_acc;
    @(posedge core_clk) disable iff (sys_rst)
      exec && op == coe_pkg::COE_OP_ORFILE && !dest_file |-> !dmem_we;
  endproperty
  a_dest_acc: assert property (p_dest_acc) else $error("File written with dest clear"); // RULE2
  property p_dest_file;
    @(posedge core_clk) disable iff (sys_rst)
      exec && op == coe_pkg::COE_OP_ORFILE && dest_file
      |-> dmem_we && dmem_wdata == (acc | dmem_rdata) ##1 $stable(acc);
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("File write-back wrong"); // RULE3
  property p_access_bank;
    @(posedge core_clk) disable iff (sys_rst)
      exec && op == coe_pkg::COE_OP_ORFILE && !instr[`COE_ACC_BIT] && instr[7]==1'b0
      |-> dmem_addr[11:8] == `COE_ACCESS_BANK;
  endproperty
  a_access_bank: assert property (p_access_bank) else $error("Access bank not used"); // RULE4

  property p_bsr_bank;
    @(posedge core_clk) disable iff (sys_rst)
      exec && instr[`COE_ACC_BIT] |-> dmem_addr == {bank_select_reg, instr[7:0]};
  endproperty
  a_bsr_bank: assert property (p_bsr_bank) else $error("Bank select ignored"); // RULE5

  property p_sub_pos;
    @(posedge core_clk) disable iff (sys_rst)
      exec && op == coe_pkg::COE_OP_SUBLIT && instr[7:0] > acc
      |=> status[`COE_FLAG_C] && !status[`COE_FLAG_Z] && acc == $past(instr[7:0] - acc);
  endproperty
  a_sub_pos: assert property (p_sub_pos) else $error("Subtract positive case wrong"); // RULE6

  property p_or_flags;
    @(posedge core_clk) disable iff (sys_rst)
      is_or |=> status[`COE_FLAG_Z] == (result_q == 8'h00) && status[`COE_FLAG_N] == result_q[7]
        && status[`COE_FLAG_C] == $past(status[`COE_FLAG_C]);
  endproperty
  a_or_flags: assert property (p_or_flags) else $error("OR flags wrong"); // RULE7

  sequence s_write_done;
    do_write ##1 bvalid;
  endsequence
  property p_bresp;
    @(posedge core_clk) disable iff (sys_rst)
      do_write |-> s_write_done;
  endproperty
  a_bresp: assert property (p_bresp) else $error("No write response");
endmodule
`default_nettype wire

// *** coe_dmem_model.sv ***
/*
  Behavioural banked data memory facing coe_exec.
  Assumes a combinational read port and at most one write per clock.
*/
`timescale 1ns/1ps
`default_nettype none

module coe_dmem_model
(
  // Clock
  input  wire logic        core_clk,
  // Access port
  input  wire logic [11:0] dmem_addr,
  output logic      [7:0]  dmem_rdata,
  input  wire logic        dmem_we,
  input  wire logic [7:0]  dmem_wdata
);
  logic [7:0] mem [4096];

  // Pattern differs per bank, so a wrong bank returns a different byte
  initial
  begin
    for (int i = 0; i < 4096; i++)
      mem[i] = 8'(i ^ (i >> 8) ^ (i >> 3));
  end

  assign dmem_rdata = mem[dmem_addr];

  always @(posedge core_clk)
  begin
    if (dmem_we === 1'b1)
      mem[dmem_addr] <= dmem_wdata;
  end
endmodule
`default_nettype wire

// *** core_or_subtract_instruction_exec_tb_top.sv ***
/*
  Self-checking bench for coe_exec with the data memory model.
  Assumes the design files and coe_dmem_model.sv are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "coe_consts.svh"

module core_or_subtract_instruction_exec_tb_top;
  logic        core_clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        dmem_we;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, dmem_rdata, dmem_wdata, acc, k, m, f;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, bank;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [11:0] dmem_addr, ea;
  logic [4:0]  st;
  typedef struct {logic [1:0] resp; logic [31:0] data; logic [31:0] mask;} coe_exp_s;
  coe_exp_s    exp_rd[$];
  logic [1:0]  exp_b[$];
  logic [19:0] exp_mw[$];
  int          miscompares, n_checks, cyc;

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  coe_exec i_dut
  (
    .core_clk, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .dmem_addr, .dmem_rdata, .dmem_we, .dmem_wdata
  );

  coe_dmem_model i_mem (.core_clk, .dmem_addr, .dmem_rdata, .dmem_we, .dmem_wdata);

  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, e, s);
    end
  endtask

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Memory writes with no note are flagged, so a stray write cannot hide
  always @(posedge core_clk)
  begin
    coe_exp_s e;
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1 && exp_rd.size() > 0)
    begin
      e = exp_rd.pop_front();
      chk("rresp", {30'h0, e.resp}, {30'h0, s_axi_rresp});
      chk("rdata", e.data & e.mask, s_axi_rdata & e.mask);
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1 && exp_b.size() > 0)
      chk("bresp", {30'h0, exp_b.pop_front()}, {30'h0, s_axi_bresp});
    // Only judged once reset is released, so the unreset start cannot flag a write
    if (sys_rst === 1'b0 && dmem_we !== 1'b0)
      chk("dmem write", {12'h0, (exp_mw.size() > 0) ? exp_mw.pop_front() : 20'hFFFFF},
          {12'h0, dmem_addr, dmem_wdata});
    cyc++;
    if (cyc > 20000)
    begin
      miscompares++;
      wrap_up();
    end
  end

  // ****************************************
  // Bus master
  // ****************************************
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge core_clk);
    exp_b.push_back(r);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (!aw_done && s_axi_awready === 1'b1)
      begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1)
      begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(aw_done && w_done));
    while (s_axi_bvalid !== 1'b1)
      @(posedge core_clk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] mk, input logic [1:0] r);
    @(posedge core_clk);
    exp_rd.push_back('{r, d, mk});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1)
      @(posedge core_clk);
    s_axi_rready <= 1'b0;
  endtask

  function automatic logic [4:0] or_flags(input logic [4:0] s, input logic [7:0] r);
    or_flags = s;
    or_flags[`COE_FLAG_N] = r[7];
    or_flags[`COE_FLAG_Z] = (r == 8'h00);
  endfunction

  task automatic expect_state(input logic [7:0] a, input logic [4:0] s, input logic [7:0] r, input logic [31:0] sm);
    axi_rd(`COE_OFF_ACC, {24'h0, a}, 32'hFFFFFFFF, `COE_RESP_OKAY);
    axi_rd(`COE_OFF_STATUS, {27'h0, s}, sm, `COE_RESP_OKAY);
    axi_rd(`COE_OFF_RESULT, {24'h0, r}, 32'hFFFFFFFF, `COE_RESP_OKAY);
  endtask

  task automatic preset(input logic [7:0] a, input logic [4:0] s);
    axi_wr(`COE_OFF_ACC, {24'h0, a}, `COE_RESP_OKAY);
    axi_wr(`COE_OFF_STATUS, {27'h0, s}, `COE_RESP_OKAY);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    sys_rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 20'h00000;
    s_axi_wdata = 32'h0;
    miscompares = 0;
    n_checks = 0;
    cyc = 0;
    void'($urandom(3));
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 5; i++)
      axi_rd(8'(4 * i), 32'h0, 32'hFFFFFFFF, `COE_RESP_OKAY);
    axi_rd(8'h14, 32'h0, 32'hFFFFFFFF, `COE_RESP_SLVERR);
    axi_wr(8'h20, 32'h5A, `COE_RESP_SLVERR);
    // Literal OR, first pass gives an all-zero result
    for (int i = 0; i < 8; i++)
    begin
      acc = (i == 0) ? 8'h00 : 8'($urandom);
      k = (i == 0) ? 8'h00 : 8'($urandom);
      st = 5'($urandom);
      preset(acc, st);
      axi_wr(`COE_OFF_INSTR, {16'h0, `COE_OP_OR_LITERAL_INTO_ACCUMULATOR_HI, k}, `COE_RESP_OKAY);
      expect_state(acc | k, or_flags(st, acc | k), acc | k, 32'h1F);
    end
    // Subtract from a larger literal, smallest gap first
    for (int i = 0; i < 4; i++)
    begin
      acc = 8'($urandom % 128);
      m = (i == 0) ? 8'h01 : 8'(1 + $urandom % 127);
      preset(acc, 5'h00);
      axi_wr(`COE_OFF_INSTR, {16'h0, `COE_OP_SUBTRACT_ACCUMULATOR_FROM_LITERAL_HI, acc + m}, `COE_RESP_OKAY);
      expect_state(m, 5'h01, m, 32'h15);
    end
    // File OR over every destination and access choice, both halves of the access bank
    for (int i = 0; i < 8; i++)
    begin
      f = {i[2], {7{i[0]}}};
      bank = 4'($urandom);
      acc = 8'($urandom);
      m = 8'($urandom);
      st = 5'($urandom);
      ea = i[1] ? {bank, f} : {f[7] ? `COE_ACCESS_HIGH : `COE_ACCESS_BANK, f};
      i_mem.mem[ea] = m;
      axi_wr(`COE_OFF_BANK, {28'h0, bank}, `COE_RESP_OKAY);
      axi_rd(`COE_OFF_BANK, {28'h0, bank}, 32'hFFFFFFFF, `COE_RESP_OKAY);
      preset(acc, st);
      if (i[0])
        exp_mw.push_back({ea, acc | m});
      axi_wr(`COE_OFF_INSTR, {16'h0, `COE_OP_OR_ACCUMULATOR_INTO_FILE_HI, i[0], i[1], f}, `COE_RESP_OKAY);
      expect_state(i[0] ? acc : acc | m, or_flags(st, acc | m), acc | m, 32'h1F);
    end
    repeat (4) @(posedge core_clk);
    chk("pending notes", 32'h0, 32'(exp_rd.size() + exp_b.size() + exp_mw.size()));
    wrap_up();
  end
endmodule
`default_nettype wire
